// *** sscr_checker.sv ***
// Purpose: Port-level assertions for the sequencer configuration bank
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to every instance of the bank
`timescale 1ns/10ps
`default_nettype none
module sscr_checker #(
   parameter int unsigned DATA_W = 16
) (
   input wire logic                       clk,
   input wire logic                       srst,
   input wire logic                       regWrite,
   input wire logic                       regRead,
   input wire logic [8:0]                 regAddr,
   input wire logic [DATA_W-1:0]          regWdata,
   input wire sscr_pkg::sscr_aec_status_t aecStatus,
   input wire logic [DATA_W-1:0]          regRdata,
   input wire logic                       regRvalid,
   input wire sscr_pkg::sscr_seq_cfg_t    seqCfg
);
   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   chk_read_answer: assert property (
      regRead |=> regRvalid) else $error("read got no valid");
   chk_valid_only: assert property (
      !regRead |=> !regRvalid) else $error("valid without read");
   chk_reset_cfg: assert property (
      $past(srst) |-> seqCfg.darkRows == 8'h02 && seqCfg.blankFirstLine
      && seqCfg.periodMeaningSelect && !seqCfg.sequencerRun)
      else $error("config not at reset values");
   chk_ctrl_follow: assert property (
      regWrite && regAddr == 9'h0C0 |-> ##2
      seqCfg.sequencerRun == $past(regWdata[0], 2) &&
      seqCfg.rollingShutter == $past(regWdata[1], 2) &&
      seqCfg.monitorSelect == $past(regWdata[13:11], 2))
      else $error("control write not applied");
   chk_global_gates: assert property (
      seqCfg.rollingShutter |-> !(seqCfg.triggeredFrames |
      seqCfg.timingFollower | seqCfg.dualSlope | seqCfg.tripleSlope))
      else $error("global option active in rolling");
   chk_rolling_only: assert property (
      !seqCfg.rollingShutter |-> seqCfg.paddingRows == 12'h000 &&
      seqCfg.lineReadoutExtension == 8'h00)
      else $error("rolling option active in global");
   chk_wait_gate: assert property (
      !seqCfg.postOverheadWaitEn |-> seqCfg.postOverheadWait == 8'h00)
      else $error("wait applied while disabled");
   chk_row_limits: assert property (
      seqCfg.darkRows != 8'h00 && seqCfg.paddingRows <= 12'h7FF)
      else $error("row count out of range");
   chk_status_read: assert property (
      regRead && regAddr == 9'h0BB |=>
      regRdata == $past(aecStatus.exposure, 2))
      else $error("exposure readback wrong");
endmodule // sscr_checker
bind sscr_sensor_sequencer_config_regs sscr_checker #(.DATA_W(DATA_W)) chk_u (
   .clk(clk), .srst(srst), .regWrite(regWrite), .regRead(regRead),
   .regAddr(regAddr), .regWdata(regWdata), .aecStatus(aecStatus),
   .regRdata(regRdata), .regRvalid(regRvalid), .seqCfg(seqCfg));
`default_nettype wire

// *** sscr_host_model.sv ***
// Purpose: Host side of the configuration port, strobe-level bus cycles
// Assumes: Bank samples strobes on the rising edge
// Notes:   Drives at the falling edge; address and data go stale after use
`timescale 1ns/10ps
`default_nettype none
module sscr_host_model (
   input  wire logic        clk,
   output logic             regWrite,
   output logic             regRead,
   output logic [8:0]       regAddr,
   output logic [15:0]      regWdata,
   input  wire logic        regRvalid,
   input  wire logic [15:0] regRdata
);
   // ------------------------------------------------------------
   // Bus cycles
   // ------------------------------------------------------------
   // Idle bus at time zero
   initial begin
      regWrite = 1'b0;
      regRead  = 1'b0;
      regAddr  = 9'h000;
      regWdata = 16'h0000;
   end

   // Stale values inverted so a late sample cannot pass by luck
   task automatic wr(input logic [8:0] a, input logic [15:0] d);
      @(negedge clk);
      regAddr  = a;
      regWdata = d;
      regWrite = 1'b1;
      @(negedge clk);
      regWrite = 1'b0;
      regAddr  = ~a;
      regWdata = ~d;
   endtask

   // Answer stands one cycle after the strobe edge
   task automatic rd(input logic [8:0] a, output logic [15:0] d,
                     output logic ok);
      @(negedge clk);
      regAddr = a;
      regRead = 1'b1;
      @(negedge clk);
      regRead = 1'b0;
      regAddr = ~a;
      ok      = (regRvalid === 1'b1);
      d       = regRdata;
   endtask
endmodule // sscr_host_model
`default_nettype wire

// *** sscr_pkg.sv ***
// Purpose: Constants and carrier types for the sequencer configuration bank
// Assumes: 9-bit register address, 16-bit data, one system clock
// Notes:   Offsets are the absolute register addresses of the bank
package sscr_pkg;
   // ---------------------------------------------------------------
   // Register addresses
   // ---------------------------------------------------------------
   localparam logic [8:0] ADDR_MEAN_LOCK  = 9'h0BA;
   localparam logic [8:0] ADDR_EXPOSURE   = 9'h0BB;
   localparam logic [8:0] ADDR_GAIN       = 9'h0BC;
   localparam logic [8:0] ADDR_SPARE_STAT = 9'h0BD;
   localparam logic [8:0] ADDR_MAIN_CTRL  = 9'h0C0;
   localparam logic [8:0] ADDR_DELAYS     = 9'h0C1;
   localparam logic [8:0] ADDR_INTEG      = 9'h0C2;
   localparam logic [8:0] ADDR_WINDOW     = 9'h0C3;
   localparam logic [8:0] ADDR_SPARE_CTRL = 9'h0C4;
   localparam logic [8:0] ADDR_DARK_ROW   = 9'h0C5;
   localparam logic [8:0] ADDR_PAD_ROWS   = 9'h0C6;

   // ---------------------------------------------------------------
   // Reset values and writable masks
   // ---------------------------------------------------------------
   localparam logic [15:0] RST_MAIN_CTRL  = 16'h0000;
   localparam logic [15:0] RST_DELAYS     = 16'h0000;
   localparam logic [15:0] RST_INTEG      = 16'h0004;
   localparam logic [15:0] RST_WINDOW     = 16'h0001;
   localparam logic [15:0] RST_SPARE_CTRL = 16'h0000;
   localparam logic [15:0] RST_DARK_ROW   = 16'h0102;
   localparam logic [15:0] RST_PAD_ROWS   = 16'h0000;
   localparam logic [15:0] MASK_MAIN_CTRL = 16'h3DF3;
   localparam logic [15:0] MASK_INTEG     = 16'h0007;
   localparam logic [15:0] MASK_WINDOW    = 16'h00FF;
   localparam logic [15:0] MASK_DARK_ROW  = 16'h01FF;
   localparam logic [15:0] MASK_PAD_ROWS  = 16'h0FFF;
   localparam logic [15:0] MASK_MEAN_LOCK = 16'h13FF;

   // ---------------------------------------------------------------
   // Field positions and limits
   // ---------------------------------------------------------------
   localparam int BIT_ENABLE    = 0;
   localparam int BIT_ROLLING   = 1;
   localparam int BIT_TRIGGER   = 4;
   localparam int BIT_FOLLOWER  = 5;
   localparam int BIT_WAIT_EN   = 6;
   localparam int BIT_SUBSAMPLE = 7;
   localparam int BIT_BINNING   = 8;
   localparam int BIT_AEC_WIN   = 10;
   localparam int MON_LSB       = 11;
   localparam int BIT_DUAL      = 0;
   localparam int BIT_TRIPLE    = 1;
   localparam int BIT_PERIOD    = 2;
   localparam int BIT_BLANK     = 8;
   localparam int BIT_LOCK      = 12;
   localparam logic [7:0]  DARK_ROWS_MIN = 8'h01;
   localparam logic [11:0] PAD_ROWS_MAX  = 12'h7FF;

   // ---------------------------------------------------------------
   // Carrier types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [15:0] exposure;
      logic [1:0]  analogGainFirst;
      logic [1:0]  analogGainSecond;
      logic [11:0] digitalGain;   // Unsigned 5.7
      logic [9:0]  mean;
      logic        locked;
   } sscr_aec_status_t;

   typedef struct packed {
      logic        sequencerRun;
      logic        rollingShutter;
      logic        triggeredFrames;
      logic        timingFollower;
      logic        postOverheadWaitEn;
      logic [7:0]  postOverheadWait;
      logic        subsampling;
      logic        binning;
      logic        aecWindowOnly;
      logic [2:0]  monitorSelect;
      logic [7:0]  lineReadoutExtension;
      logic        dualSlope;
      logic        tripleSlope;
      logic        periodMeaningSelect;
      logic [7:0]  windowSelect;
      logic [7:0]  darkRows;
      logic        blankFirstLine;
      logic [11:0] paddingRows;
   } sscr_seq_cfg_t;
endpackage

// *** sscr_sensor_sequencer_config_regs.sv ***
// Function
// - Enable bit idles or runs sequencer
// - Bit 1 picks global or rolling
// - Triggered frames, global shutter only
// - Follower timing, global shutter only
// - Wait bit inserts post-overhead delay
// - Wait length from delay bits 15:8
// - Subsampling on or off
// - Binning on or off
// - Statistics over all or window
// - Monitor pin source select
// - Rolling line readout extension length
// - Dual slope, global shutter only
// - Triple slope, global shutter only
// - Period meaning select, resets one
// - Dark rows 1..255, never zero
// - Blank first line when set
// - Padding rows rolling only, max 2047
// - Report mean and lock, read only
// - Report exposure and gain, read only
// - Period counts in multiplier units
//
// Purpose: Configuration bank of the frame sequencer with loop readback
// Assumes: Serial port logic delivers decoded one-cycle write/read strobes
// Notes:   Read data is registered, valid one cycle after the read strobe
`timescale 1ns/10ps
`default_nettype none
module sscr_sensor_sequencer_config_regs #(
   parameter int unsigned DATA_W = 16
) (
   input  wire logic                      clk,
   input  wire logic                      srst,
   input  wire logic                      regWrite,
   input  wire logic                      regRead,
   input  wire logic [8:0]                regAddr,
   input  wire logic [DATA_W-1:0]         regWdata,
   input  wire sscr_pkg::sscr_aec_status_t aecStatus,
   output logic [DATA_W-1:0]              regRdata,
   output logic                           regRvalid,
   output sscr_pkg::sscr_seq_cfg_t        seqCfg
);

   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   logic [15:0] mainCtrl_reg;
   logic [15:0] delays_reg;
   logic [15:0] integ_reg;
   logic [15:0] window_reg;
   logic [15:0] spareCtrl_reg;
   logic [15:0] darkRow_reg;
   logic [15:0] padRows_reg;
   logic [15:0] meanLock_reg;
   logic [15:0] exposure_reg;
   logic [15:0] gain_reg;
   logic [15:0] rdata_next;
   sscr_pkg::sscr_seq_cfg_t cfg_next;

   // Write strobe decode shared by all writable registers
   function automatic logic hit(input logic [8:0] a);
      return regWrite && (regAddr == a);
   endfunction

   // ---------------------------------------------------------------
   // Control writes
   // ---------------------------------------------------------------
   // Reserved bits are masked so they always read back as zero
   always_ff @(posedge clk) begin
      if (srst) begin
         mainCtrl_reg <= sscr_pkg::RST_MAIN_CTRL;  // Idle at reset
      end else if (hit(sscr_pkg::ADDR_MAIN_CTRL)) begin
         mainCtrl_reg <= regWdata & sscr_pkg::MASK_MAIN_CTRL;
      end
   end

   // Delay register is fully writable
   always_ff @(posedge clk) begin
      if (srst) begin
         delays_reg <= sscr_pkg::RST_DELAYS;
      end else if (hit(sscr_pkg::ADDR_DELAYS)) begin
         delays_reg <= regWdata;
      end
   end

   // Period meaning bit resets to frame length
   always_ff @(posedge clk) begin
      if (srst) begin
         integ_reg <= sscr_pkg::RST_INTEG;
      end else if (hit(sscr_pkg::ADDR_INTEG)) begin
         integ_reg <= regWdata & sscr_pkg::MASK_INTEG;
      end
   end

   // Window selection
   always_ff @(posedge clk) begin
      if (srst) begin
         window_reg <= sscr_pkg::RST_WINDOW;
      end else if (hit(sscr_pkg::ADDR_WINDOW)) begin
         window_reg <= regWdata & sscr_pkg::MASK_WINDOW;
      end
   end

   // Spare control word is kept as plain storage
   always_ff @(posedge clk) begin
      if (srst) begin
         spareCtrl_reg <= sscr_pkg::RST_SPARE_CTRL;
      end else if (hit(sscr_pkg::ADDR_SPARE_CTRL)) begin
         spareCtrl_reg <= regWdata;
      end
   end

   // A zero dark-row count would stall the frame, so it is lifted to one
   always_ff @(posedge clk) begin
      if (srst) begin
         darkRow_reg <= sscr_pkg::RST_DARK_ROW;
      end else if (hit(sscr_pkg::ADDR_DARK_ROW)) begin
         darkRow_reg <= regWdata & sscr_pkg::MASK_DARK_ROW;
         if (regWdata[7:0] == 8'h00) begin
            darkRow_reg[7:0] <= sscr_pkg::DARK_ROWS_MIN;
         end
      end
   end

   // Padding count above 2047 saturates rather than wrapping
   always_ff @(posedge clk) begin
      if (srst) begin
         padRows_reg <= sscr_pkg::RST_PAD_ROWS;
      end else if (hit(sscr_pkg::ADDR_PAD_ROWS)) begin
         if ((regWdata[11:0]) > sscr_pkg::PAD_ROWS_MAX) begin
            padRows_reg <= {4'h0, sscr_pkg::PAD_ROWS_MAX};
         end else begin
            padRows_reg <= regWdata & sscr_pkg::MASK_PAD_ROWS;
         end
      end
   end

   // ---------------------------------------------------------------
   // Loop status capture
   // ---------------------------------------------------------------
   // Captured from the loop every cycle; bus writes never touch them
   always_ff @(posedge clk) begin
      if (srst) begin
         meanLock_reg <= 16'h0000;
         exposure_reg <= 16'h0000;
         gain_reg     <= 16'h0000;
      end else begin
         meanLock_reg <= {3'h0, aecStatus.locked, 2'h0,
                          aecStatus.mean};
         exposure_reg <= aecStatus.exposure;
         gain_reg     <= {aecStatus.digitalGain,
                          aecStatus.analogGainSecond,
                          aecStatus.analogGainFirst};
      end
   end

   // ---------------------------------------------------------------
   // Read mux
   // ---------------------------------------------------------------
   // Unmapped addresses read as zero
   always_comb begin
      case (regAddr)
         sscr_pkg::ADDR_MEAN_LOCK:  rdata_next = meanLock_reg;
         sscr_pkg::ADDR_EXPOSURE:   rdata_next = exposure_reg;
         sscr_pkg::ADDR_GAIN:       rdata_next = gain_reg;
         sscr_pkg::ADDR_MAIN_CTRL:  rdata_next = mainCtrl_reg;
         sscr_pkg::ADDR_DELAYS:     rdata_next = delays_reg;
         sscr_pkg::ADDR_INTEG:      rdata_next = integ_reg;
         sscr_pkg::ADDR_WINDOW:     rdata_next = window_reg;
         sscr_pkg::ADDR_SPARE_CTRL: rdata_next = spareCtrl_reg;
         sscr_pkg::ADDR_DARK_ROW:   rdata_next = darkRow_reg;
         sscr_pkg::ADDR_PAD_ROWS:   rdata_next = padRows_reg;
         default:                   rdata_next = 16'h0000;
      endcase
   end

   // Registered read answer
   always_ff @(posedge clk) begin
      if (srst) begin
         regRdata  <= '0;
         regRvalid <= 1'b0;
      end else begin
         regRvalid <= regRead;
         if (regRead) begin
            regRdata <= DATA_W'(rdata_next);
         end
      end
   end

   // ---------------------------------------------------------------
   // Effective sequencer configuration
   // ---------------------------------------------------------------
   // Global-only options are gated off in rolling mode so the sequencer
   // never sees a combination it cannot honour
   always_comb begin
      logic gs;
      gs = ~mainCtrl_reg[sscr_pkg::BIT_ROLLING];
      cfg_next.sequencerRun    = mainCtrl_reg[sscr_pkg::BIT_ENABLE];
      cfg_next.rollingShutter  = ~gs;
      cfg_next.triggeredFrames = gs &
                                 mainCtrl_reg[sscr_pkg::BIT_TRIGGER];
      cfg_next.timingFollower  = gs &
                                 mainCtrl_reg[sscr_pkg::BIT_FOLLOWER];
      cfg_next.postOverheadWaitEn =
         mainCtrl_reg[sscr_pkg::BIT_WAIT_EN];
      cfg_next.postOverheadWait =
         mainCtrl_reg[sscr_pkg::BIT_WAIT_EN] ? delays_reg[15:8]
                                             : 8'h00;
      cfg_next.subsampling   = mainCtrl_reg[sscr_pkg::BIT_SUBSAMPLE];
      cfg_next.binning       = mainCtrl_reg[sscr_pkg::BIT_BINNING];
      cfg_next.aecWindowOnly = mainCtrl_reg[sscr_pkg::BIT_AEC_WIN];
      cfg_next.monitorSelect =
         mainCtrl_reg[sscr_pkg::MON_LSB +: 3];
      cfg_next.lineReadoutExtension =
         gs ? 8'h00 : delays_reg[7:0];
      cfg_next.dualSlope   = gs & integ_reg[sscr_pkg::BIT_DUAL];
      cfg_next.tripleSlope = gs & integ_reg[sscr_pkg::BIT_TRIPLE];
      // Period counts in multiplier units, applied by the timer
      cfg_next.periodMeaningSelect = integ_reg[sscr_pkg::BIT_PERIOD];
      cfg_next.windowSelect   = window_reg[7:0];
      cfg_next.darkRows       = darkRow_reg[7:0];
      cfg_next.blankFirstLine = darkRow_reg[sscr_pkg::BIT_BLANK];
      cfg_next.paddingRows    = gs ? 12'h000 : padRows_reg[11:0];
   end

   // Configuration output comes straight from a flip-flop
   always_ff @(posedge clk) begin
      if (srst) begin
         seqCfg <= '0;
         seqCfg.periodMeaningSelect <= 1'b1;
         seqCfg.windowSelect        <= sscr_pkg::RST_WINDOW[7:0];
         seqCfg.darkRows            <= sscr_pkg::RST_DARK_ROW[7:0];
         seqCfg.blankFirstLine      <= 1'b1;
      end else begin
         seqCfg <= cfg_next;
      end
   end

endmodule // sscr_sensor_sequencer_config_regs
`default_nettype wire

// *** sscr_sensor_sequencer_config_regs_tb_top.sv ***
// Purpose: Self-checking bench for the sequencer configuration bank
// Assumes: Host model owns the bus; bench owns reset and loop status
// Notes:   Config views are zero-extended to share one compare task
`timescale 1ns/10ps
`default_nettype none
module sscr_sensor_sequencer_config_regs_tb_top;
   logic                       clk;
   logic                       srst;
   logic                       regWrite;
   logic                       regRead;
   logic [8:0]                 regAddr;
   logic [15:0]                regWdata;
   logic [15:0]                regRdata;
   logic                       regRvalid;
   sscr_pkg::sscr_aec_status_t aecStatus;
   sscr_pkg::sscr_seq_cfg_t    seqCfg;
   int                         badCount;
   int                         testsRun;
   // Control view laid out like the main control register bits
   wire logic [15:0] ctrlV = {2'h0, seqCfg.monitorSelect,
                              seqCfg.aecWindowOnly, 1'b0,
                              seqCfg.binning, seqCfg.subsampling,
                              seqCfg.postOverheadWaitEn,
                              seqCfg.timingFollower,
                              seqCfg.triggeredFrames, 2'h0,
                              seqCfg.rollingShutter,
                              seqCfg.sequencerRun};
   wire logic [15:0] dlyV  = {seqCfg.postOverheadWait,
                              seqCfg.lineReadoutExtension};
   wire logic [15:0] intV  = {13'h0000, seqCfg.periodMeaningSelect,
                              seqCfg.tripleSlope, seqCfg.dualSlope};
   wire logic [15:0] rowV  = {7'h00, seqCfg.blankFirstLine, seqCfg.darkRows};

   sscr_sensor_sequencer_config_regs dut_u (.clk(clk), .srst(srst),
      .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
      .regWdata(regWdata), .aecStatus(aecStatus), .regRdata(regRdata),
      .regRvalid(regRvalid), .seqCfg(seqCfg));
   sscr_host_model host_u (.clk(clk), .regWrite(regWrite),
      .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
      .regRvalid(regRvalid), .regRdata(regRdata));

   // ------------------------------------------------------------
   // Compare and report
   // ------------------------------------------------------------
   task automatic cmp(input string n, input logic [15:0] e, logic [15:0] g);
      testsRun++;
      if (g !== e) begin
         badCount++;
         $display("mismatch %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic chkRd(input logic [8:0] a, input logic [15:0] e);
      logic [15:0] d;
      logic        ok;
      host_u.rd(a, d, ok);
      cmp("rvalid", 16'h0001, {15'h0000, ok});
      cmp($sformatf("reg %h", a), e, d);
   endtask
   // Config lands one edge after the write edge
   task automatic wrS(input logic [8:0] a, input logic [15:0] d);
      host_u.wr(a, d);
      repeat (2) @(negedge clk);
   endtask
   task automatic stopTest();
      $display("compares %0d mismatches %0d", testsRun, badCount);
      if (badCount == 0 && testsRun > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic tReset();
      chkRd(9'h0C0, 16'h0000);
      chkRd(9'h0C1, 16'h0000);
      chkRd(9'h0C3, 16'h0001);
      chkRd(9'h0C2, 16'h0004);
      chkRd(9'h0C5, 16'h0102);
      chkRd(9'h0C6, 16'h0000);
      chkRd(9'h0BD, 16'h0000);
   endtask
   task automatic tControl();
      wrS(9'h0C0, 16'hFFFF);
      chkRd(9'h0C0, 16'h3DF3);
      cmp("ctrl rolling", 16'h3DC3, ctrlV);
      wrS(9'h0C0, 16'h3DF1);
      cmp("ctrl global", 16'h3DF1, ctrlV);
      wrS(9'h0C0, 16'h0000);
      cmp("ctrl idle", 16'h0000, ctrlV);
   endtask
   task automatic tDelays();
      host_u.wr(9'h0C1, 16'hA55A);
      wrS(9'h0C0, 16'h0003);
      cmp("delay no wait", 16'h005A, dlyV);
      wrS(9'h0C0, 16'h0043);
      cmp("delay wait", 16'hA55A, dlyV);
      wrS(9'h0C0, 16'h0041);
      cmp("delay global", 16'hA500, dlyV);
   endtask
   task automatic tInteg();
      wrS(9'h0C2, 16'hFFFF);
      chkRd(9'h0C2, 16'h0007);
      cmp("integ global", 16'h0007, intV);
      wrS(9'h0C0, 16'h0003);
      cmp("integ rolling", 16'h0004, intV);
      wrS(9'h0C2, 16'h0000);
      cmp("integ reset len", 16'h0000, intV);
   endtask
   task automatic tRows();
      host_u.wr(9'h0C5, 16'h0000);
      wrS(9'h0C6, 16'h0FFF);
      cmp("dark rows", 16'h0001, rowV);
      cmp("pad rows", 16'h07FF, {4'h0, seqCfg.paddingRows});
      wrS(9'h0C0, 16'h0001);
      cmp("pad global", 16'h0000, {4'h0, seqCfg.paddingRows});
      wrS(9'h0C3, 16'hFFA5);
      cmp("window", 16'h00A5, {8'h00, seqCfg.windowSelect});
   endtask
   // Status writes must bounce off the read-only registers
   task automatic tStatus();
      @(negedge clk);
      aecStatus = {16'h1234, 2'h1, 2'h2, 12'hABC, 10'h2A5, 1'b1};
      host_u.wr(9'h0BB, 16'hFFFF);
      host_u.wr(9'h0BA, 16'hFFFF);
      chkRd(9'h0BB, 16'h1234);
      chkRd(9'h0BC, 16'hABC9);
      chkRd(9'h0BA, 16'h12A5);
      chkRd(9'h0A0, 16'h0000);
   endtask

   // ------------------------------------------------------------
   // Clock, sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Second reset mid-run proves reset values after real traffic
   initial begin
      srst      = 1'b1;
      aecStatus = '0;
      badCount  = 0;
      testsRun  = 0;
      repeat (12) @(negedge clk);
      srst = 1'b0;
      tReset();
      tControl();
      tDelays();
      tInteg();
      tRows();
      tStatus();
      srst = 1'b1;
      repeat (2) @(negedge clk);
      srst = 1'b0;
      tReset();
      stopTest();
   end
   initial begin
      #1000000;
      badCount++;
      stopTest();
   end
endmodule // sscr_sensor_sequencer_config_regs_tb_top
`default_nettype wire
